// File: design/bled_menu.sv
/*
 * Single-button function menu with five leds and a beeper.
 * Engines for reading, aiming, calibration and learning sit on the
 * same clock and talk through one-cycle pulses and levels; the button is a pin.
 */
// Function
// [RULE1] Status led lights at once on press
// [RULE2] Hold cycles leds; release enters lit function
// [RULE3] Cycle order test, aim, setup, learn
// [RULE4] Test mode shows read rate bar graph
// [RULE5] Test no-read: only status led blinks
// [RULE6] One press leaves test mode
// [RULE7] Test mode ends after three minutes
// [RULE8] Aim: lasers on, aim led blinks
// [RULE9] Liquid lens: autofocus after short delay
// [RULE10] Press in aim: delayed cancel, lasers off
// [RULE11] Setup led blinks until calibration ends
// [RULE12] Calibration ok: stop blink, three high beeps
// [RULE13] Calibration 5 s timeout: long low beep
// [RULE14] Learn led blinks until learning ends
// [RULE15] Learn ok: good spot, three high beeps
// [RULE16] Learn 3 min timeout: long low beep
// [RULE17] Press in learn cancels after delay
// [RULE18] Error: status and ready blink together
// [RULE19] Diagnostic message only when enabled
// [RULE20] Debounced press counts as one event
// [RULE21] Error pattern keeps other leds off
`timescale 1ns/1ps
`default_nettype none
module bled_menu import bled_pkg::*; #(
	parameter int MS_CYCLES = BLED_MS_CYC,
	parameter int TEST_TO_MS = BLED_TEST_TO_MS,
	parameter int LEARN_TO_MS = BLED_LEARN_TO_MS
) (
	// clock, reset, freeze
	input wire logic clk_sys,
	input wire logic reset,
	input wire logic clk_en,
	// operator side
	input wire logic button_n,
	input wire logic lens_fitted,
	output logic led_ready,
	output logic led_good,
	output logic led_trigger,
	output logic link_activity_led,
	output logic led_status,
	output logic beep_on,
	output logic beep_high,
	// engine status
	input wire logic no_read,
	input wire logic [2:0] rate_level,
	input wire logic cal_ok,
	input wire logic learn_ok,
	input wire logic error_present,
	input wire logic diag_en,
	// engine commands
	output logic laser_on,
	output logic af_start,
	output logic af_cancel,
	output logic cal_start,
	output logic cal_abort,
	output logic learn_start,
	output logic learn_abort,
	output logic diag_send
);

	logic [1:0] btn_sync_q;
	logic [1:0] lens_sync_q;
	logic [31:0] ms_cnt_q;
	logic tick_q;
	logic [7:0] deb_q;
	logic btn_db_q, btn_prev_q, press_q, rel_q;
	logic [BLED_TW-1:0] blink_cnt_q;
	logic blink_q;
	bled_state_t st_q;
	logic [1:0] sel_q;
	logic [BLED_TW-1:0] tmr_q;
	logic laser_q, af_done_q, af_start_q, af_cancel_q;
	logic cal_start_q, cal_abort_q, learn_start_q, learn_abort_q;
	logic beep_go_q, beep_long_q, spot_go_q;
	logic [1:0] left_q;
	logic bon_q, bhigh_q, spot_q;
	logic [BLED_BW-1:0] btmr_q;
	logic err_prev_q, diag_q;
	logic [4:0] leds_d, leds_q;

	// thermometer code for the read-rate bar
	function automatic logic [4:0] bled_bar(input logic [2:0] r);
		case (r)
			3'h0: bled_bar = 5'h00;
			3'h1: bled_bar = 5'h01;
			3'h2: bled_bar = 5'h03;
			3'h3: bled_bar = 5'h07;
			3'h4: bled_bar = 5'h0F;
			default: bled_bar = 5'h1F;
		endcase
	endfunction

	// pin synchronisers; first stage feeds only the second
	always_ff @(posedge clk_sys or posedge reset) begin
		if (reset) begin
			btn_sync_q <= 2'h0;
			lens_sync_q <= 2'h0;
		end else if (clk_en) begin
			btn_sync_q <= {btn_sync_q[0], ~button_n};
			lens_sync_q <= {lens_sync_q[0], lens_fitted};
		end
	end

	// millisecond tick shared by every timer
	always_ff @(posedge clk_sys or posedge reset) begin
		if (reset) begin
			ms_cnt_q <= 32'h0;
			tick_q <= 1'b0;
		end else if (clk_en) begin
			tick_q <= (ms_cnt_q == 32'(MS_CYCLES - 1));
			if (ms_cnt_q == 32'(MS_CYCLES - 1))
				ms_cnt_q <= 32'h0;
			else
				ms_cnt_q <= ms_cnt_q + 32'h1;
		end
	end

	// [RULE20] debounce, edge pulses
	always_ff @(posedge clk_sys or posedge reset) begin
		if (reset) begin
			deb_q <= 8'h0;
			btn_db_q <= 1'b0;
			btn_prev_q <= 1'b0;
			press_q <= 1'b0;
			rel_q <= 1'b0;
		end else if (clk_en) begin
			btn_prev_q <= btn_db_q;
			press_q <= btn_db_q & ~btn_prev_q;
			rel_q <= ~btn_db_q & btn_prev_q;
			if (btn_sync_q[1] == btn_db_q) begin
				deb_q <= 8'h0;
			end else if (tick_q) begin
				if (deb_q == 8'(BLED_DEB_MS - 1)) begin
					btn_db_q <= btn_sync_q[1];
					deb_q <= 8'h0;
				end else begin
					deb_q <= deb_q + 8'h1;
				end
			end
		end
	end

	// blink square wave, common phase for all leds
	always_ff @(posedge clk_sys or posedge reset) begin
		if (reset) begin
			blink_cnt_q <= '0;
			blink_q <= 1'b0;
		end else if (clk_en && tick_q) begin
			if (blink_cnt_q == BLED_TW'(BLED_BLINK_MS - 1)) begin
				blink_cnt_q <= '0;
				blink_q <= ~blink_q;
			end else begin
				blink_cnt_q <= blink_cnt_q + 1'b1;
			end
		end
	end

	// function state machine with its millisecond timer
	always_ff @(posedge clk_sys or posedge reset) begin
		if (reset) begin
			st_q <= ST_IDLE;
			sel_q <= BLED_FN_TEST;
			tmr_q <= '0;
			laser_q <= 1'b0;
			af_done_q <= 1'b0;
			af_start_q <= 1'b0;
			af_cancel_q <= 1'b0;
			cal_start_q <= 1'b0;
			cal_abort_q <= 1'b0;
			learn_start_q <= 1'b0;
			learn_abort_q <= 1'b0;
			beep_go_q <= 1'b0;
			beep_long_q <= 1'b0;
			spot_go_q <= 1'b0;
		end else if (clk_en) begin
			af_start_q <= 1'b0;
			af_cancel_q <= 1'b0;
			cal_start_q <= 1'b0;
			cal_abort_q <= 1'b0;
			learn_start_q <= 1'b0;
			learn_abort_q <= 1'b0;
			beep_go_q <= 1'b0;
			spot_go_q <= 1'b0;
			if (tick_q)
				tmr_q <= tmr_q + 1'b1;
			case (st_q)
				ST_IDLE: begin
					if (press_q) begin
						st_q <= ST_MENU;
						sel_q <= BLED_FN_TEST;
						tmr_q <= '0;
					end
				end
				ST_MENU: begin
					// [RULE2] release enters the lit function
					if (rel_q) begin
						tmr_q <= '0;
						case (sel_q)
							BLED_FN_TEST: st_q <= ST_TEST;
							BLED_FN_AIM: begin
								st_q <= ST_AIM;
								laser_q <= 1'b1;
								af_done_q <= 1'b0;
							end
							BLED_FN_SETUP: begin
								st_q <= ST_SETUP;
								cal_start_q <= 1'b1;
							end
							default: begin
								st_q <= ST_LEARN;
								learn_start_q <= 1'b1;
							end
						endcase
					// [RULE3] step to next function
					end else if (tick_q &&
					    tmr_q == BLED_TW'(BLED_STEP_MS - 1)) begin
						sel_q <= sel_q + 2'h1;
						tmr_q <= '0;
					end
				end
				ST_TEST: begin
					// [RULE6] [RULE7] press or timeout
					if (press_q || (tick_q &&
					    tmr_q == BLED_TW'(TEST_TO_MS - 1)))
						st_q <= ST_IDLE;
				end
				ST_AIM: begin
					if (press_q) begin
						st_q <= ST_AIM_X;
						tmr_q <= '0;
					// [RULE9] autofocus after delay
					end else if (tick_q && lens_sync_q[1] &&
					    !af_done_q &&
					    tmr_q == BLED_TW'(BLED_DLY_MS - 1)) begin
						af_start_q <= 1'b1;
						af_done_q <= 1'b1;
					end
				end
				ST_AIM_X: begin
					// [RULE10] delayed cancel, lasers off
					if (tick_q && tmr_q == BLED_TW'(BLED_DLY_MS - 1)) begin
						af_cancel_q <= af_done_q;
						laser_q <= 1'b0;
						st_q <= ST_IDLE;
					end
				end
				ST_SETUP: begin
					// [RULE12] success beats a coincident timeout
					if (cal_ok) begin
						beep_go_q <= 1'b1;
						beep_long_q <= 1'b0;
						st_q <= ST_IDLE;
					// [RULE13] abandon, long beep
					end else if (tick_q &&
					    tmr_q == BLED_TW'(BLED_SETUP_TO_MS - 1)) begin
						cal_abort_q <= 1'b1;
						beep_go_q <= 1'b1;
						beep_long_q <= 1'b1;
						st_q <= ST_IDLE;
					end
				end
				ST_LEARN: begin
					// [RULE15] success with good spot
					if (learn_ok) begin
						beep_go_q <= 1'b1;
						beep_long_q <= 1'b0;
						spot_go_q <= 1'b1;
						st_q <= ST_IDLE;
					end else if (press_q) begin
						st_q <= ST_LEARN_X;
						tmr_q <= '0;
					// [RULE16] abandon, long beep
					end else if (tick_q &&
					    tmr_q == BLED_TW'(LEARN_TO_MS - 1)) begin
						learn_abort_q <= 1'b1;
						beep_go_q <= 1'b1;
						beep_long_q <= 1'b1;
						st_q <= ST_IDLE;
					end
				end
				ST_LEARN_X: begin
					// [RULE17] delayed learn cancel
					if (tick_q && tmr_q == BLED_TW'(BLED_DLY_MS - 1)) begin
						learn_abort_q <= 1'b1;
						st_q <= ST_IDLE;
					end
				end
				default: st_q <= ST_IDLE;
			endcase
		end
	end

	// beep sequencer; spot stays lit while the beeps play
	always_ff @(posedge clk_sys or posedge reset) begin
		if (reset) begin
			left_q <= 2'h0;
			bon_q <= 1'b0;
			bhigh_q <= 1'b0;
			btmr_q <= '0;
			spot_q <= 1'b0;
		end else if (clk_en) begin
			if (beep_go_q) begin
				left_q <= beep_long_q ? BLED_BEEPS_FAIL : BLED_BEEPS_OK;
				bon_q <= 1'b1;
				bhigh_q <= ~beep_long_q;
				btmr_q <= '0;
				spot_q <= spot_go_q;
			end else if (bon_q) begin
				if (tick_q) begin
					if (btmr_q == (bhigh_q ?
					    BLED_BW'(BLED_BEEP_SHORT_MS - 1) :
					    BLED_BW'(BLED_BEEP_LONG_MS - 1))) begin
						bon_q <= 1'b0;
						left_q <= left_q - 2'h1;
						btmr_q <= '0;
					end else begin
						btmr_q <= btmr_q + 1'b1;
					end
				end
			end else if (left_q != 2'h0) begin
				if (tick_q) begin
					if (btmr_q == BLED_BW'(BLED_BEEP_GAP_MS - 1)) begin
						bon_q <= 1'b1;
						btmr_q <= '0;
					end else begin
						btmr_q <= btmr_q + 1'b1;
					end
				end
			end else begin
				spot_q <= 1'b0;
			end
		end
	end

	// [RULE19] diagnostic report on new error, only if enabled
	always_ff @(posedge clk_sys or posedge reset) begin
		if (reset) begin
			err_prev_q <= 1'b0;
			diag_q <= 1'b0;
		end else if (clk_en) begin
			err_prev_q <= error_present;
			diag_q <= error_present & ~err_prev_q & diag_en;
		end
	end

	// led pattern per state
	always_comb begin
		leds_d = 5'h00;
		case (st_q)
			ST_IDLE: begin
				// [RULE18] [RULE21] error pattern
				if (error_present) begin
					leds_d[BLED_LED_READY] = blink_q;
					leds_d[BLED_LED_STATUS] = blink_q;
				end else begin
					leds_d[BLED_LED_READY] = 1'b1;
					leds_d[BLED_LED_GOOD] = spot_q;
				end
			end
			ST_MENU: begin
				// [RULE1] status feedback while held
				leds_d[BLED_LED_STATUS] = 1'b1;
				leds_d[sel_q] = 1'b1;
			end
			ST_TEST: begin
				// [RULE4] [RULE5] bar graph or no-read blink
				if (no_read)
					leds_d[BLED_LED_STATUS] = blink_q;
				else
					leds_d = bled_bar(rate_level);
			end
			// [RULE8] aim led blinks
			ST_AIM, ST_AIM_X: leds_d[BLED_LED_GOOD] = blink_q;
			// [RULE11] setup led blinks
			ST_SETUP: leds_d[BLED_LED_TRIG] = blink_q;
			// [RULE14] learn led blinks
			ST_LEARN, ST_LEARN_X: leds_d[BLED_LED_LINK] = blink_q;
			default: leds_d = 5'h00;
		endcase
	end

	// registered leds keep outputs glitch free
	always_ff @(posedge clk_sys or posedge reset) begin
		if (reset)
			leds_q <= 5'h00;
		else if (clk_en)
			leds_q <= leds_d;
	end

	// outputs, all straight from flip-flops
	assign led_ready = leds_q[BLED_LED_READY];
	assign led_good = leds_q[BLED_LED_GOOD];
	assign led_trigger = leds_q[BLED_LED_TRIG];
	assign link_activity_led = leds_q[BLED_LED_LINK];
	assign led_status = leds_q[BLED_LED_STATUS];
	assign beep_on = bon_q;
	assign beep_high = bhigh_q;
	assign laser_on = laser_q;
	assign af_start = af_start_q;
	assign af_cancel = af_cancel_q;
	assign cal_start = cal_start_q;
	assign cal_abort = cal_abort_q;
	assign learn_start = learn_start_q;
	assign learn_abort = learn_abort_q;
	assign diag_send = diag_q;

	// checks
	property p_menu_status;
		@(posedge clk_sys) disable iff (reset)
		(st_q == ST_MENU && clk_en) |=> led_status;
	endproperty
	a_menu_status: assert property (p_menu_status) // [RULE1]
		else $error("status led dark in menu");

	property p_rel_aim;
		@(posedge clk_sys) disable iff (reset)
		(st_q == ST_MENU && rel_q && sel_q == BLED_FN_AIM && clk_en)
		|=> (st_q == ST_AIM && laser_on);
	endproperty
	a_rel_aim: assert property (p_rel_aim) // [RULE2]
		else $error("release did not enter aim");

	property p_sel_step;
		@(posedge clk_sys) disable iff (reset)
		(st_q == ST_MENU && $past(st_q) == ST_MENU &&
		 sel_q != $past(sel_q))
		|-> sel_q == $past(sel_q) + 2'h1;
	endproperty
	a_sel_step: assert property (p_sel_step) // [RULE3]
		else $error("menu skipped a function");

	property p_bar;
		@(posedge clk_sys) disable iff (reset)
		(st_q == ST_TEST && !no_read && clk_en)
		|=> leds_q == bled_bar($past(rate_level));
	endproperty
	a_bar: assert property (p_bar) // [RULE4]
		else $error("bar graph wrong");

	property p_noread;
		@(posedge clk_sys) disable iff (reset)
		(st_q == ST_TEST && no_read && clk_en) |=> leds_q[3:0] == 4'h0;
	endproperty
	a_noread: assert property (p_noread) // [RULE5]
		else $error("leds lit during no read");

	property p_test_exit;
		@(posedge clk_sys) disable iff (reset)
		(st_q == ST_TEST && press_q && clk_en) |=> st_q == ST_IDLE;
	endproperty
	a_test_exit: assert property (p_test_exit) // [RULE6]
		else $error("press did not leave test");

	property p_af_start;
		@(posedge clk_sys) disable iff (reset)
		af_start |-> (st_q == ST_AIM && lens_sync_q[1] && laser_on);
	endproperty
	a_af_start: assert property (p_af_start) // [RULE9]
		else $error("autofocus started outside aim");

	property p_af_cancel;
		@(posedge clk_sys) disable iff (reset)
		af_cancel |-> (!laser_on && st_q == ST_IDLE);
	endproperty
	a_af_cancel: assert property (p_af_cancel) // [RULE10]
		else $error("cancel without lasers off");

	property p_cal_fail;
		@(posedge clk_sys) disable iff (reset)
		cal_abort |-> (beep_long_q && beep_go_q) ##1 (beep_on && !beep_high);
	endproperty
	a_cal_fail: assert property (p_cal_fail) // [RULE13]
		else $error("no long beep on calibration timeout");

	property p_err_leds;
		@(posedge clk_sys) disable iff (reset)
		(st_q == ST_IDLE && error_present && clk_en)
		|=> (leds_q[3:1] == 3'h0 && led_ready == led_status);
	endproperty
	a_err_leds: assert property (p_err_leds) // [RULE18]
		else $error("error pattern wrong");

	property p_diag;
		@(posedge clk_sys) disable iff (reset)
		diag_send |-> $past(diag_en);
	endproperty
	a_diag: assert property (p_diag) // [RULE19]
		else $error("diagnostic sent while disabled");

	property p_press_once;
		@(posedge clk_sys) disable iff (reset)
		press_q |=> !press_q;
	endproperty
	a_press_once: assert property (p_press_once) // [RULE20]
		else $error("press counted twice");

endmodule
`default_nettype wire

// File: design/bled_pkg.sv
/*
 * Constants and types for the push-button / LED / beeper menu block.
 * Assumes a 40 MHz system clock; all times are held in milliseconds
 * and turned into cycles through the millisecond tick count.
 */
package bled_pkg;

	// clock rate and the millisecond tick derived from it
	localparam int BLED_CLK_HZ = 40_000_000;
	localparam int BLED_MS_CYC = BLED_CLK_HZ / 1000;

	// times in milliseconds
	localparam int BLED_DEB_MS = 20;
	localparam int BLED_STEP_MS = 1000;
	localparam int BLED_BLINK_MS = 250;
	localparam int BLED_DLY_MS = 500;
	localparam int BLED_SETUP_TO_MS = 5000;
	localparam int BLED_TEST_TO_MS = 180000;
	localparam int BLED_LEARN_TO_MS = 180000;
	localparam int BLED_BEEP_SHORT_MS = 100;
	localparam int BLED_BEEP_GAP_MS = 100;
	localparam int BLED_BEEP_LONG_MS = 1000;

	// counter widths
	localparam int BLED_TW = 18;
	localparam int BLED_BW = 10;

	// beep counts
	localparam logic [1:0] BLED_BEEPS_OK = 2'h3;
	localparam logic [1:0] BLED_BEEPS_FAIL = 2'h1;

	// led positions; function led index equals the menu selection
	localparam int BLED_LED_READY = 0;
	localparam int BLED_LED_GOOD = 1;
	localparam int BLED_LED_TRIG = 2;
	localparam int BLED_LED_LINK = 3;
	localparam int BLED_LED_STATUS = 4;

	// menu selections in cycle order
	localparam logic [1:0] BLED_FN_TEST = 2'h0;
	localparam logic [1:0] BLED_FN_AIM = 2'h1;
	localparam logic [1:0] BLED_FN_SETUP = 2'h2;
	localparam logic [1:0] BLED_FN_LEARN = 2'h3;

	typedef enum logic [2:0] {
		ST_IDLE,
		ST_MENU,
		ST_TEST,
		ST_AIM,
		ST_AIM_X,
		ST_SETUP,
		ST_LEARN,
		ST_LEARN_X
	} bled_state_t;

endpackage

// File: verification/bled_operator.sv
/*
 * Operator model: presses and releases the push button on request.
 * Assumes the bench holds each request far longer than the bounce.
 */
`timescale 1ns/1ps
`default_nettype none
module bled_operator (
	// clock
	input wire logic clk_sys,
	// request from the bench
	input wire logic hold_req,
	// button pin, pulled up while released
	output logic button_n
);
	// hold, then release
	// contact bounce; each burst is shorter than the debounce window
	// one process owns the pin, released level first
	initial begin
		button_n = 1'b1;
		forever begin
			@(hold_req);
			repeat (4) begin
				@(negedge clk_sys);
				button_n = ~hold_req;
				repeat (5) @(negedge clk_sys);
				button_n = hold_req;
			end
			@(negedge clk_sys);
			button_n = ~hold_req;
		end
	end
endmodule
`default_nettype wire

// File: verification/testbench.sv
/*
 * Self-checking bench for the menu block.
 * Assumes the operator model and a 40 MHz clock; times are shortened.
 */
`timescale 1ns/1ps
`default_nettype none
module testbench import bled_pkg::*; ;
	localparam int MS = 2;
	localparam int TO = 400;
	localparam int STEP = BLED_STEP_MS * MS;
	localparam int DLY = BLED_DLY_MS * MS;
	localparam int BLK = BLED_BLINK_MS * MS;
	localparam int SHORT = 3 * BLED_BEEP_SHORT_MS * MS;
	localparam int LONG = BLED_BEEP_LONG_MS * MS;
	localparam int LIMIT = 80000;

	// bench drives
	logic clk_sys = 1'b0;
	logic reset = 1'b1;
	logic clk_en = 1'b1;
	logic hold_req = 1'b0;
	logic lens_fitted = 1'b0;
	logic no_read = 1'b0;
	logic [2:0] rate_level = 3'h0;
	logic cal_ok = 1'b0;
	logic learn_ok = 1'b0;
	logic error_present = 1'b0;
	logic diag_en = 1'b0;
	wire logic button_n;
	wire logic led_ready, led_good, led_trigger, link_activity_led;
	wire logic led_status, beep_on, beep_high, laser_on, af_start;
	wire logic af_cancel, cal_start, cal_abort, learn_start, learn_abort;
	wire logic diag_send;
	wire logic [14:0] obs;
	int failures = 0;
	int checks_done = 0;
	int cyc = 0;
	int t;
	int t0;

	// all observed outputs side by side, leds in the low bits
	assign obs = {diag_send, learn_abort, learn_start, cal_abort, cal_start,
		af_cancel, af_start, laser_on, beep_high, beep_on, led_status,
		link_activity_led, led_trigger, led_good, led_ready};

	bled_menu #(.MS_CYCLES(MS), .TEST_TO_MS(TO), .LEARN_TO_MS(2 * TO)) uut (
		.clk_sys(clk_sys), .reset(reset), .clk_en(clk_en),
		.button_n(button_n), .lens_fitted(lens_fitted),
		.led_ready(led_ready), .led_good(led_good),
		.led_trigger(led_trigger), .link_activity_led(link_activity_led),
		.led_status(led_status), .beep_on(beep_on), .beep_high(beep_high),
		.no_read(no_read), .rate_level(rate_level), .cal_ok(cal_ok),
		.learn_ok(learn_ok), .error_present(error_present),
		.diag_en(diag_en), .laser_on(laser_on), .af_start(af_start),
		.af_cancel(af_cancel), .cal_start(cal_start),
		.cal_abort(cal_abort), .learn_start(learn_start),
		.learn_abort(learn_abort), .diag_send(diag_send));

	bled_operator op (.clk_sys(clk_sys), .hold_req(hold_req),
		.button_n(button_n));

	// clock and hang guard
	always #12.5 clk_sys = ~clk_sys;
	always @(posedge clk_sys) begin
		cyc <= cyc + 1;
		if (cyc == LIMIT) begin
			failures++;
			give_verdict();
		end
	end

	task give_verdict;
		$display("checks_done=%0d failures=%0d", checks_done, failures);
		if (failures == 0 && checks_done > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask

	task chk(input logic [15:0] got, input logic [15:0] exp);
		checks_done++;
		if (got !== exp) begin
			failures++;
			$display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	// bounded wait on one output, sampled mid-cycle where it is settled
	task wait_bit(input int b, input logic v, input int max);
		t = 0;
		while (obs[b] !== v && t < max) begin
			@(negedge clk_sys);
			t++;
		end
		chk(obs[b], v);
	endtask

	// hold the button through the menu until function k is lit
	task enter_fn(input int k);
		@(negedge clk_sys);
		hold_req = 1'b1;
		wait_bit(4, 1'b1, 300);
		wait_bit(k, 1'b1, 4 * STEP);
		hold_req = 1'b0;
		repeat (150) @(negedge clk_sys);
		t0 = cyc - 150;
	endtask

	task press;
		@(negedge clk_sys);
		hold_req = 1'b1;
		repeat (200) @(negedge clk_sys);
		hold_req = 1'b0;
	endtask

	// bursts, total sound time, tone and mode leds seen meanwhile
	task judge_beeps(input int nexp, input int len, input logic hexp,
		input logic [2:0] lexp);
		int n;
		int on;
		logic hi;
		logic prev;
		logic [2:0] lit;
		n = 0;
		on = 0;
		hi = 1'b0;
		prev = 1'b0;
		lit = 3'h0;
		repeat (len + 1200) begin
			@(negedge clk_sys);
			if (beep_on === 1'b1 && prev !== 1'b1)
				n++;
			if (beep_on === 1'b1)
				hi |= beep_high;
			if (beep_on === 1'b1)
				on++;
			lit |= obs[3:1];
			prev = beep_on;
		end
		chk(n, nexp);
		chk(on >= len - 8 && on <= len + 8, 1);
		chk(hi, hexp);
		chk(lit, lexp);
	endtask

	task t_menu_learn;
		chk(obs[4:0], 5'h01);
		@(negedge clk_sys);
		hold_req = 1'b1;
		wait_bit(4, 1'b1, 130);
		for (int k = 0; k < 4; k++) begin
			wait_bit(k, 1'b1, STEP + 50);
			chk(obs[3:0], 16'h1 << k);
		end
		hold_req = 1'b0;
		wait_bit(12, 1'b1, 200);
		wait_bit(3, ~obs[3], BLK + 20);
		learn_ok = 1'b1;
		@(negedge clk_sys);
		learn_ok = 1'b0;
		judge_beeps(3, SHORT, 1'b1, 3'h1);
	endtask

	task t_test;
		enter_fn(0);
		for (int r = 0; r < 6; r++) begin
			rate_level = 3'(r);
			repeat (3) @(negedge clk_sys);
			chk(obs[4:0], (16'h1 << r) - 16'h1);
		end
		no_read = 1'b1;
		repeat (3) @(negedge clk_sys);
		chk(obs[3:0], 4'h0);
		wait_bit(4, ~obs[4], BLK + 20);
		wait_bit(0, 1'b1, TO * MS);
		chk(cyc - t0 >= TO * MS && cyc - t0 <= TO * MS + 200, 1);
		no_read = 1'b0;
		rate_level = 3'h0;
	endtask

	task t_test_press;
		enter_fn(0);
		press();
		repeat (300) @(negedge clk_sys);
		chk(obs[4:0], 5'h01);
	endtask

	task t_aim;
		lens_fitted = 1'b1;
		enter_fn(1);
		chk(laser_on, 1'b1);
		wait_bit(1, ~obs[1], BLK + 20);
		wait_bit(8, 1'b1, DLY);
		chk(cyc - t0 >= DLY && cyc - t0 <= DLY + 200, 1);
		t0 = cyc;
		press();
		wait_bit(9, 1'b1, DLY + 200);
		chk(cyc - t0 >= DLY && cyc - t0 <= DLY + 200, 1);
		repeat (2) @(negedge clk_sys);
		chk(laser_on, 1'b0);
		lens_fitted = 1'b0;
	endtask

	// entered by hand so the start pulse is still seen
	task t_setup_ok;
		@(negedge clk_sys);
		hold_req = 1'b1;
		wait_bit(4, 1'b1, 300);
		wait_bit(2, 1'b1, 4 * STEP);
		hold_req = 1'b0;
		wait_bit(10, 1'b1, 200);
		wait_bit(2, ~obs[2], BLK + 20);
		cal_ok = 1'b1;
		@(negedge clk_sys);
		cal_ok = 1'b0;
		judge_beeps(3, SHORT, 1'b1, 3'h0);
	endtask

	task t_setup_to;
		enter_fn(2);
		wait_bit(11, 1'b1, BLED_SETUP_TO_MS * MS);
		chk(cyc - t0 >= BLED_SETUP_TO_MS * MS &&
			cyc - t0 <= BLED_SETUP_TO_MS * MS + 200, 1);
		judge_beeps(1, LONG, 1'b0, 3'h0);
	endtask

	task t_learn_press;
		enter_fn(3);
		t0 = cyc;
		press();
		wait_bit(13, 1'b1, DLY + 200);
		chk(cyc - t0 >= DLY && cyc - t0 <= DLY + 200, 1);
		repeat (200) @(negedge clk_sys);
	endtask

	task t_learn_to;
		enter_fn(3);
		wait_bit(13, 1'b1, 2 * TO * MS);
		chk(cyc - t0 >= 2 * TO * MS &&
			cyc - t0 <= 2 * TO * MS + 200, 1);
		judge_beeps(1, LONG, 1'b0, 3'h0);
	endtask

	task t_error;
		int bad;
		int tog;
		logic p;
		// frozen block must neither report nor move its leds
		clk_en = 1'b0;
		diag_en = 1'b1;
		error_present = 1'b1;
		repeat (20) @(negedge clk_sys);
		chk(obs, 16'h0001);
		clk_en = 1'b1;
		wait_bit(14, 1'b1, 3);
		bad = 0;
		tog = 0;
		p = obs[0];
		repeat (2 * BLK + 100) begin
			@(negedge clk_sys);
			if (obs[4] !== obs[0] || obs[3:1] !== 3'h0)
				bad++;
			if (obs[0] !== p)
				tog++;
			p = obs[0];
		end
		chk(bad, 0);
		chk(tog >= 2, 1);
		error_present = 1'b0;
		diag_en = 1'b0;
		repeat (5) @(negedge clk_sys);
		error_present = 1'b1;
		bad = 0;
		repeat (20) begin
			@(negedge clk_sys);
			if (diag_send !== 1'b0)
				bad++;
		end
		chk(bad, 0);
		error_present = 1'b0;
	endtask

	// reset, then each scenario in turn
	initial begin
		repeat (12) @(negedge clk_sys);
		reset = 1'b0;
		repeat (10) @(negedge clk_sys);
		t_menu_learn();
		t_test();
		t_test_press();
		t_aim();
		t_setup_ok();
		t_setup_to();
		t_learn_press();
		t_learn_to();
		t_error();
		give_verdict();
	end
endmodule
`default_nettype wire
